// ===== hdl/ppi_bus_if.sv
// processor-side link between the bus master and the two port chips
interface ppi_bus_if;
    logic [1:0] cs_n;
    logic [1:0] addr;
    logic rd_n;
    logic wr_n;
    logic [7:0] h_data;
    logic h_oe;
    logic [7:0] d_data;
    logic d_oe;
    modport host (output cs_n, addr, rd_n, wr_n, h_data, h_oe, input d_data, d_oe);
    modport dev (input cs_n, addr, rd_n, wr_n, h_data, h_oe, output d_data, d_oe);
endinterface

// ===== hdl/ppi_dev.sv
// two programmable parallel port chips with baud counter, keyboard and clock glue
//
// The implementer's own choice: the Wishbone slave port.
module ppi_core
    import ppi_pkg::*;
(
    input wire logic clk_i,          // clock
    input wire logic rst_i,          // sync reset
    input wire logic wr_stb_i,       // one-cycle write pulse, selected
    input wire logic [1:0] addr_i,   // register select
    input wire logic [7:0] wdata_i,  // write data
    input wire logic [7:0] a_pin_i,  // port a pins
    input wire logic [7:0] b_pin_i,  // port b pins
    input wire logic [7:0] c_pin_i,  // port c pins
    output logic [7:0] rdata_o,      // read value
    output logic [7:0] b_o,          // port b output latch
    output logic [7:0] c_o,          // port c output latch
    output logic flag_o,             // strobed-input flag
    output logic busy_o              // strobed-input busy
);
    logic [7:0] cw_r, a_out_r, b_out_r, c_out_r, a_lat_r, b_lat_r, c_oe;
    logic flag_r, busy_r, stb_a_d_r, m1a, m1b, set_flag;
    // mode 2 codes fall back to mode 1, the bidirectional bus is not built
    assign m1a = cw_r[CW_AMODE_HI] | cw_r[CW_AMODE_LO];
    assign m1b = cw_r[CW_BMODE];
    // handshake bits of a strobed register are never driven
    assign c_oe = {{4{~cw_r[CW_CHDIR]}}, {4{~cw_r[CW_CLDIR]}}}
                  & ~(m1a ? C_MASK_A1 : 8'h00) & ~(m1b ? C_MASK_B1 : 8'h00);
    assign set_flag = m1a & c_pin_i[C_A_STB] & ~stb_a_d_r & ~busy_r & c_out_r[C_KEY_CLR];
    assign b_o = b_out_r;
    assign c_o = c_out_r;
    assign flag_o = flag_r;
    assign busy_o = busy_r;
    // ==================================================
    // control word: mode set only, set/reset form leaves it alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cw_r <= CW_RESET;
        end else if (wr_stb_i && addr_i == SEL_CTRL && wdata_i[CW_MODESET]) begin
            cw_r <= wdata_i;
        end
    end
    // output latches; a mode set clears them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_out_r <= 8'h00;
            b_out_r <= 8'h00;
            c_out_r <= 8'h00;
        end else if (wr_stb_i) begin
            unique case (addr_i)
                SEL_A: a_out_r <= wdata_i;
                SEL_B: b_out_r <= wdata_i;
                SEL_C: c_out_r <= wdata_i;
                SEL_CTRL: begin
                    if (wdata_i[CW_MODESET]) begin
                        a_out_r <= 8'h00;
                        b_out_r <= 8'h00;
                        c_out_r <= 8'h00;
                    end else begin
                        c_out_r[wdata_i[BSR_SEL_HI:BSR_SEL_LO]] <= wdata_i[BSR_VAL];
                    end
                end
            endcase
        end
    end
    // strobed input latches: transparent while strobe low (a only while not busy), held after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_lat_r <= 8'h00;
            b_lat_r <= 8'h00;
        end else begin
            if (m1a && !c_pin_i[C_A_STB] && !busy_r) begin
                a_lat_r <= a_pin_i;
            end
            if (m1b && !c_pin_i[C_B_STB]) begin
                b_lat_r <= b_pin_i;
            end
        end
    end
    // flag: a low c6 holds it clear and also blocks the set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stb_a_d_r <= 1'b1;
            flag_r <= 1'b0;
        end else begin
            stb_a_d_r <= c_pin_i[C_A_STB];
            if (set_flag) begin
                flag_r <= 1'b1;
            end else if (!c_out_r[C_KEY_CLR]) begin
                flag_r <= 1'b0;
            end
        end
    end
    // busy drops only once flag is clear and c6 is high again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (set_flag) begin
            busy_r <= 1'b1;
        end else if (!flag_r && c_out_r[C_KEY_CLR]) begin
            busy_r <= 1'b0;
        end
    end
    // read mux: mode 0 inputs pass straight from the pins
    always_comb begin
        rdata_o = 8'h00;
        unique case (addr_i)
            SEL_A: rdata_o = cw_r[CW_ADIR] ? (m1a ? a_lat_r : a_pin_i) : a_out_r;
            SEL_B: rdata_o = cw_r[CW_BDIR] ? (m1b ? b_lat_r : b_pin_i) : b_out_r;
            SEL_C: rdata_o = (c_out_r & c_oe) | (c_pin_i & ~c_oe);
            SEL_CTRL: rdata_o = 8'h00;
        endcase
    end
endmodule

module ppi_dev
    import ppi_pkg::*;
#(
    parameter int RTC_CYCLES = RTC_CYC  // one-shot length in clocks
) (
    input wire logic clk_i,           // clock, processor phase two
    input wire logic rst_i,           // sync reset
    ppi_bus_if.dev bus,               // processor link
    input wire logic cd_i,            // carrier detect
    input wire logic cts_i,           // clear to send
    input wire logic [1:0] jumper_i,  // line option jumpers
    input wire logic rx_ready_i,      // serial receive ready
    input wire logic tx_ready_i,      // serial send ready
    input wire logic [7:0] key_data_i, // keyboard data
    input wire logic key_strobe_n_i,  // keyboard strobe, low
    input wire logic [7:0] fkey_i,    // function keys and options
    input wire logic sync_i,          // processor sync
    output logic baud_clk_o,          // serial clock square wave
    output logic key_busy_o,          // keyboard busy
    output logic rtc_run_o,           // one-shot running
    output logic irq_o                // processor interrupt request
);
    localparam int RW = $clog2(RTC_CYCLES + 1);
    logic wr_d_r, wr_stb, one_sel, baud_r, c7_d_r, rtc_run_r, rtc_irq_r, irq_r;
    logic [7:0] rd1, rd2, factor, en1, c2, d_data_r, cnt_r;
    logic d_oe_r, key_flag, key_busy;
    logic [RW-1:0] rtc_cnt_r;
    // ==================================================
    // write pulse on the falling write strobe, data is valid with it
    assign wr_stb = ~bus.wr_n & wr_d_r;
    assign one_sel = bus.cs_n[0] ^ bus.cs_n[1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_d_r <= 1'b1;
        end else begin
            wr_d_r <= bus.wr_n;
        end
    end
    // status port: its a register carries the board status
    ppi_core u_stat (
        .clk_i(clk_i), .rst_i(rst_i), .wr_stb_i(wr_stb & ~bus.cs_n[0]),
        .addr_i(bus.addr), .wdata_i(bus.h_data),
        .a_pin_i({rtc_irq_r, key_flag, cts_i, cd_i, jumper_i, 2'b00}),
        .b_pin_i(8'h00), .c_pin_i(8'h00),
        .rdata_o(rd1), .b_o(factor), .c_o(en1), .flag_o(), .busy_o()
    );
    // keyboard port: sync inverted so b latches while sync is high
    ppi_core u_key (
        .clk_i(clk_i), .rst_i(rst_i), .wr_stb_i(wr_stb & ~bus.cs_n[1]),
        .addr_i(bus.addr), .wdata_i(bus.h_data),
        .a_pin_i(key_data_i), .b_pin_i(fkey_i),
        .c_pin_i({3'b000, key_strobe_n_i, 1'b0, ~sync_i, 2'b00}),
        .rdata_o(rd2), .b_o(), .c_o(c2), .flag_o(key_flag), .busy_o(key_busy)
    );
    // read data registered; nothing is driven if two selects overlap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d_data_r <= 8'h00;
            d_oe_r <= 1'b0;
        end else begin
            d_data_r <= bus.cs_n[0] ? rd2 : rd1;
            d_oe_r <= ~bus.rd_n & one_sel;
        end
    end
    assign bus.d_data = d_data_r;
    assign bus.d_oe = d_oe_r;
    // ==================================================
    // baud counter; the factor is sampled only at reload time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 8'h00;
            baud_r <= 1'b0;
        end else if (&cnt_r) begin
            cnt_r <= factor;
            baud_r <= ~baud_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // ==================================================
    // one-shot: non-retriggerable, a rise while running is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c7_d_r <= 1'b0;
            rtc_run_r <= 1'b0;
            rtc_cnt_r <= '0;
        end else begin
            c7_d_r <= c2[C_RTC];
            if (c2[C_RTC] && !c7_d_r && !rtc_run_r) begin
                rtc_run_r <= 1'b1;
                rtc_cnt_r <= RW'(RTC_CYCLES - 1);
            end else if (rtc_run_r) begin
                if (rtc_cnt_r == '0) begin
                    rtc_run_r <= 1'b0;
                end else begin
                    rtc_cnt_r <= rtc_cnt_r - RW'(1);
                end
            end
        end
    end
    // clock interrupt: set at expiry, cleared by the low re-arm, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rtc_irq_r <= 1'b0;
        end else if (rtc_run_r && rtc_cnt_r == '0) begin
            rtc_irq_r <= 1'b1;
        end else if (!c2[C_RTC]) begin
            rtc_irq_r <= 1'b0;
        end
    end
    // interrupt request gated by the status port enable bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |({rtc_irq_r, key_flag, tx_ready_i, rx_ready_i} & en1[C_EN_LO+3:C_EN_LO]);
        end
    end
    assign baud_clk_o = baud_r;
    assign key_busy_o = key_busy;
    assign rtc_run_o = rtc_run_r;
    assign irq_o = irq_r;
endmodule

// ===== hdl/ppi_host.sv
// processor-side master: wishbone command registers driving the port link
module ppi_host
    import ppi_pkg::*;
(
    input wire logic clk_i,           // clock
    input wire logic rst_i,           // sync reset
    input wire logic wb_cyc_i,        // wishbone cycle
    input wire logic wb_stb_i,        // wishbone strobe
    input wire logic wb_we_i,         // wishbone write
    input wire logic [7:0] wb_adr_i,  // byte address
    input wire logic [3:0] wb_sel_i,  // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o,     // read data
    output logic wb_ack_o,            // acknowledge
    ppi_bus_if.host bus               // port link
);
    ppi_hstate_t state_r;
    logic ack_r, read_r, port_r, rd_n_r, wr_n_r, h_oe_r, req, start;
    logic [1:0] cs_n_r, addr_r;
    logic [7:0] wdata_r, rd_data_r;
    logic [31:0] dat_r;
    logic [1:0] cnt_r;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // a command is taken at the ack edge, where the master still holds it; one while busy is acked but dropped
    assign start = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & (wb_adr_i == WB_CMD)
                   & (&wb_sel_i[1:0]) & (state_r == H_IDLE);
    // ==================================================
    // wishbone slave: ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            dat_r <= 32'h0000_0000;
            if (req && !wb_we_i && wb_adr_i == WB_STAT) begin
                dat_r <= {16'h0000, rd_data_r, 7'h00, state_r != H_IDLE};
            end
        end
    end
    // latched command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdata_r <= 8'h00;
            addr_r <= 2'h0;
            port_r <= 1'b0;
            read_r <= 1'b0;
        end else if (start) begin
            wdata_r <= wb_dat_i[7:0];
            addr_r <= wb_dat_i[CMD_ADDR_LO+1:CMD_ADDR_LO];
            port_r <= wb_dat_i[CMD_PORT];
            read_r <= wb_dat_i[CMD_READ];
        end
    end
    // ==================================================
    // link sequencer: select, strobe, release; one select at a time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= H_IDLE;
            cs_n_r <= 2'b11;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            h_oe_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            unique case (state_r)
                H_IDLE: begin
                    if (start) begin
                        state_r <= H_SETUP;
                        cs_n_r <= wb_dat_i[CMD_PORT] ? 2'b01 : 2'b10;
                    end
                end
                H_SETUP: begin
                    state_r <= H_STROBE;
                    rd_n_r <= ~read_r;
                    wr_n_r <= read_r;
                    h_oe_r <= ~read_r;
                    cnt_r <= 2'(STROBE_CYC - 1);
                end
                H_STROBE: begin
                    if (cnt_r == 2'h0) begin
                        state_r <= H_HOLD;
                        rd_n_r <= 1'b1;
                        wr_n_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 2'h1;
                    end
                end
                H_HOLD: begin
                    state_r <= H_IDLE;
                    cs_n_r <= 2'b11;
                    h_oe_r <= 1'b0;
                end
            endcase
        end
    end
    // read data taken at the last strobe edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_r <= 8'h00;
        end else if (state_r == H_STROBE && cnt_r == 2'h0 && read_r && bus.d_oe) begin
            rd_data_r <= bus.d_data;
        end
    end
    assign bus.cs_n = cs_n_r;
    assign bus.addr = addr_r;
    assign bus.rd_n = rd_n_r;
    assign bus.wr_n = wr_n_r;
    assign bus.h_data = wdata_r;
    assign bus.h_oe = h_oe_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
endmodule

// ===== hdl/ppi_pkg.sv
// shared constants and types of the parallel port pair and its bus master
package ppi_pkg;
    // ==================================================
    // register select codes on the two address lines
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;
    localparam logic [1:0] SEL_CTRL = 2'h3;
    // ==================================================
    // control word layout
    localparam int CW_MODESET = 7;
    localparam int CW_AMODE_HI = 6;
    localparam int CW_AMODE_LO = 5;
    localparam int CW_ADIR = 4;
    localparam int CW_CHDIR = 3;
    localparam int CW_BMODE = 2;
    localparam int CW_BDIR = 1;
    localparam int CW_CLDIR = 0;
    localparam int BSR_SEL_HI = 3;
    localparam int BSR_SEL_LO = 1;
    localparam int BSR_VAL = 0;
    localparam logic [7:0] CW_RESET = 8'h9b;
    localparam logic [7:0] C_MASK_A1 = 8'h38;
    localparam logic [7:0] C_MASK_B1 = 8'h07;
    // ==================================================
    // third register bit roles
    localparam int C_B_STB = 2;
    localparam int C_A_STB = 4;
    localparam int C_KEY_CLR = 6;
    localparam int C_RTC = 7;
    localparam int C_EN_LO = 4;
    // status bits of the first register on the status port
    localparam int ST_JMP_LO = 2;
    localparam int ST_CD = 4;
    localparam int ST_CTS = 5;
    localparam int ST_KEY = 6;
    localparam int ST_RTC = 7;
    // ==================================================
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    localparam int RTC_MS = 10;
    localparam int RTC_CYC = CLK_HZ / 1000 * RTC_MS;
    localparam int STROBE_NS = 75;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // ==================================================
    // host wishbone map
    localparam logic [7:0] WB_CMD = 8'h00;
    localparam logic [7:0] WB_STAT = 8'h04;
    localparam int CMD_ADDR_LO = 8;
    localparam int CMD_PORT = 10;
    localparam int CMD_READ = 11;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RD_LO = 8;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_STROBE = 2'b10,
        H_HOLD = 2'b11
    } ppi_hstate_t;
endpackage

// ===== test/ppi_props.sv
// checker for the processor link between the host master and the two port chips
module ppi_props (
    input wire logic clk_i,        // clock
    input wire logic rst_i,        // sync reset
    input wire logic [1:0] cs_n,   // chip selects, low
    input wire logic [1:0] addr,   // register select
    input wire logic rd_n,         // read strobe, low
    input wire logic wr_n,         // write strobe, low
    input wire logic [7:0] h_data, // host data
    input wire logic h_oe,         // host drives bus
    input wire logic [7:0] d_data, // device data
    input wire logic d_oe          // device drives bus
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==================================================
    // one clock domain, so clocking and disable are given once
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic one_sel;
    // exactly one chip selected
    assign one_sel = (cs_n == 2'b01) || (cs_n == 2'b10);
    // ==================================================
    // link assertions
    one_sel_a: assert property (cs_n != 2'b00) else $error("both chips selected");
    strobe_sel_a: assert property ((!rd_n || !wr_n) |-> one_sel && (rd_n || wr_n))
        else $error("strobe without single select");
    addr_hold_a: assert property ((!rd_n || !wr_n) |-> $stable(addr) && $stable(cs_n))
        else $error("select moved under strobe");
    wr_len_a: assert property ($fell(wr_n) |-> (!wr_n) [*3] ##1 wr_n)
        else $error("write strobe length wrong");
    rd_len_a: assert property ($fell(rd_n) |-> (!rd_n) [*3] ##1 rd_n)
        else $error("read strobe length wrong");
    sel_release_a: assert property ($rose(wr_n) |-> one_sel ##1 (cs_n == 2'b11 && !h_oe))
        else $error("select not held then released");
    wdata_hold_a: assert property ((!wr_n && !$past(wr_n)) |-> h_oe && $stable(h_data))
        else $error("write data not held");
    no_fight_a: assert property (!(h_oe && d_oe)) else $error("both ends drive bus");
    rd_drive_a: assert property ((!$past(rd_n) && $past(one_sel)) |-> d_oe)
        else $error("device did not drive read");
    rd_quiet_a: assert property (d_oe |-> !$past(rd_n)) else $error("device drove unasked");
    // main traffic seen
    cover property ($fell(wr_n) && cs_n == 2'b01);
    cover property ($fell(rd_n) && cs_n == 2'b10);
    cover property ($rose(d_oe));
endmodule

// ===== test/testbench.sv
// self-checking bench for the host master and port chips joined by their link
module testbench;
    import ppi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic ST = 1'b0;
    localparam logic KB = 1'b1;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic cd, cts, rx_rdy, tx_rdy, key_stb_n, sync, baud_clk, key_busy, rtc_run, irq;
    logic [1:0] jumper;
    logic [7:0] key_data, fkey, q;
    int err_count, samples_checked;
    ppi_bus_if bus_if ();
    ppi_host u_ppi_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .bus(bus_if));
    // short one-shot keeps the run brief
    ppi_dev #(.RTC_CYCLES(20)) u_ppi_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .cd_i(cd),
        .cts_i(cts), .jumper_i(jumper), .rx_ready_i(rx_rdy), .tx_ready_i(tx_rdy),
        .key_data_i(key_data), .key_strobe_n_i(key_stb_n), .fkey_i(fkey), .sync_i(sync),
        .baud_clk_o(baud_clk), .key_busy_o(key_busy), .rtc_run_o(rtc_run), .irq_o(irq));
    ppi_props u_ppi_props (.clk_i(clk_i), .rst_i(rst_i), .cs_n(bus_if.cs_n), .addr(bus_if.addr),
        .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .h_data(bus_if.h_data), .h_oe(bus_if.h_oe),
        .d_data(bus_if.d_data), .d_oe(bus_if.d_oe));
    // ==================================================
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ==================================================
    // reporting
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        $display("[ERR] %0t %s", $time, m);
        err_count++;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fail(m);
        end
    endtask
    // ==================================================
    // bus cycles; ack is read at the edge, before that edge's updates land
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            fail("no ack");
            wrap_up();
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // one link transfer; status is polled until the master is idle
    task automatic cmd(input logic port, input logic [1:0] ra, input logic [7:0] d, input logic rd);
        logic [31:0] s;
        int n;
        wb(1'b1, WB_CMD, {20'h0, rd, port, ra, d}, s);
        n = 0;
        do begin
            wb(1'b0, WB_STAT, 32'h0, s);
            n++;
        end while (s[STAT_BUSY] !== 1'b0 && n < 20);
        if (s[STAT_BUSY] !== 1'b0) begin
            fail("master stuck busy");
            wrap_up();
        end
        q = s[15:8];
    endtask
    task automatic baud_gap(output int n);
        logic v;
        v = baud_clk;
        n = 0;
        while (baud_clk === v && n < 600) begin
            @(posedge clk_i);
            n++;
        end
        if (baud_clk === v) begin
            fail("baud clock stuck");
            wrap_up();
        end
    endtask
    // ==================================================
    // scenarios
    task automatic t_status();
        logic [31:0] s;
        cd <= 1'b1;
        jumper <= 2'b10;
        cmd(ST, SEL_CTRL, 8'h90, 1'b0);
        cmd(ST, SEL_A, 8'h00, 1'b1);
        chk(q & 8'hfc, 8'h18, "status inputs");
        cd <= 1'b0;
        cts <= 1'b1;
        jumper <= 2'b01;
        cmd(ST, SEL_A, 8'h00, 1'b1);
        chk(q & 8'hfc, 8'h24, "inputs not following pins");
        wb(1'b0, 8'h08, 32'h0, s);
        chk(s[7:0], 8'h00, "unmapped read");
    endtask
    task automatic t_baud();
        int n;
        logic [31:0] s;
        cmd(ST, SEL_B, 8'hfc, 1'b0);
        cmd(ST, SEL_B, 8'h00, 1'b1);
        chk(q, 8'hfc, "output latch readback");
        baud_gap(n);
        baud_gap(n);
        chk(n[7:0], 8'h04, "baud high half");
        baud_gap(n);
        chk(n[7:0], 8'h04, "baud low half");
        // a second command while the master is busy must be dropped
        wb(1'b1, WB_CMD, {20'h0, 1'b0, ST, SEL_B, 8'h11}, s);
        cmd(ST, SEL_B, 8'h22, 1'b0);
        cmd(ST, SEL_B, 8'h00, 1'b1);
        chk(q, 8'h11, "command taken while busy");
    endtask
    task automatic t_bsr();
        logic [7:0] w[4] = '{8'h0f, 8'h0b, 8'h0e, 8'h01};
        logic [7:0] e[4] = '{8'h80, 8'ha0, 8'h20, 8'h21};
        cmd(ST, SEL_C, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cmd(ST, SEL_CTRL, w[i], 1'b0);
            cmd(ST, SEL_C, 8'h00, 1'b1);
            chk(q, e[i], "bit set or clear");
        end
        cmd(ST, SEL_C, 8'h00, 1'b0);
    endtask
    task automatic t_irq();
        rx_rdy <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00, "receive not masked");
        cmd(ST, SEL_C, 8'h10, 1'b0);
        chk({7'h0, irq}, 8'h01, "receive irq missing");
        cmd(ST, SEL_C, 8'h20, 1'b0);
        chk({7'h0, irq}, 8'h00, "send enable wrong source");
        tx_rdy <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h0, irq}, 8'h01, "send irq missing");
        rx_rdy <= 1'b0;
        tx_rdy <= 1'b0;
        cmd(ST, SEL_C, 8'h00, 1'b0);
    endtask
    task automatic t_key();
        cmd(KB, SEL_CTRL, 8'hb7, 1'b0);
        cmd(KB, SEL_CTRL, 8'h0d, 1'b0);
        cmd(ST, SEL_C, 8'h40, 1'b0);
        key_data <= 8'h5a;
        key_stb_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        key_stb_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h0, key_busy}, 8'h01, "busy not set");
        chk({7'h0, irq}, 8'h01, "keyboard irq missing");
        // a strobe while busy must be ignored
        key_data <= 8'ha5;
        key_stb_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        key_stb_n <= 1'b1;
        cmd(KB, SEL_A, 8'h00, 1'b1);
        chk(q, 8'h5a, "key byte not held");
        cmd(ST, SEL_A, 8'h00, 1'b1);
        chk(q & 8'h40, 8'h40, "status key flag");
        cmd(ST, SEL_C, 8'h00, 1'b0);
        chk({7'h0, irq}, 8'h00, "keyboard irq not masked");
        cmd(KB, SEL_CTRL, 8'h0c, 1'b0);
        chk({7'h0, key_busy}, 8'h01, "busy left before re-arm");
        cmd(ST, SEL_A, 8'h00, 1'b1);
        chk(q & 8'h40, 8'h00, "key flag not cleared");
        cmd(KB, SEL_CTRL, 8'h0d, 1'b0);
        chk({7'h0, key_busy}, 8'h00, "busy stuck");
    endtask
    task automatic t_fkey();
        cmd(ST, SEL_C, 8'h40, 1'b0);
        fkey <= 8'h3c;
        sync <= 1'b1;
        repeat (2) @(posedge clk_i);
        sync <= 1'b0;
        @(posedge clk_i);
        fkey <= 8'hc3;
        cmd(KB, SEL_B, 8'h00, 1'b1);
        chk(q, 8'h3c, "function keys not latched");
        chk({7'h0, irq}, 8'h00, "function keys raised irq");
        cmd(ST, SEL_C, 8'h00, 1'b0);
    endtask
    task automatic t_rtc();
        cmd(KB, SEL_CTRL, 8'h0f, 1'b0);
        chk({7'h0, rtc_run}, 8'h01, "one-shot not fired");
        repeat (25) @(posedge clk_i);
        chk({7'h0, rtc_run}, 8'h00, "one-shot too long");
        cmd(ST, SEL_A, 8'h00, 1'b1);
        chk(q & 8'h80, 8'h80, "clock flag missing");
        cmd(ST, SEL_C, 8'h80, 1'b0);
        chk({7'h0, irq}, 8'h01, "clock irq missing");
        cmd(KB, SEL_CTRL, 8'h0f, 1'b0);
        chk({7'h0, rtc_run}, 8'h00, "fired without re-arm");
        cmd(KB, SEL_CTRL, 8'h0e, 1'b0);
        chk({7'h0, irq}, 8'h00, "clock irq not cleared");
        cmd(KB, SEL_CTRL, 8'h0f, 1'b0);
        chk({7'h0, rtc_run}, 8'h01, "re-armed shot not fired");
        cmd(ST, SEL_C, 8'h00, 1'b0);
    endtask
    // ==================================================
    // main sequence
    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, cd, cts, rx_rdy, tx_rdy, sync} = 9'h100;
        {wb_adr, wb_dat_w, jumper, key_data, fkey} = 58'h0;
        wb_sel = 4'hf;
        key_stb_n = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_status();
        t_baud();
        t_bsr();
        t_irq();
        t_key();
        t_fkey();
        t_rtc();
        wrap_up();
    end
endmodule
